// [msc_cfg.svh]
// Offsets, field positions, reset values and counts of the memory config registers
//----------------------------------------------------------------------
// Functional notes
// - Bits 5:3, reset 1, limit fixed-priority wait for SRAM bank one.
// - Bits 2:0, reset 1, limit fixed-priority wait for SRAM bank zero.
// - Wait codes 1..7 mean that many cycles; code 0 means 8.
// - Bit 16, reset 0, turns both flash sense amplifiers on together.
// - Bit 15 clear: flash resets on system and power-on reset; set: power-on only.
// - Bit 14, reset 0, puts flash array one in deep power-down.
// - Bit 13, reset 0, puts flash array zero in deep power-down.
// - Bits 12:5 reset 0x7; low nibble is array zero, high nibble array one.
// - Range codes 0,1 unsupported; 2..15 give page-read 3..16, program 2..7.
// - Bits 4:0, reset 0x11, size the flash segment remapped to address zero.
// - Remap codes 0x0d..0x12 mean 16 to 512 Kbytes; lower codes reserved.
//----------------------------------------------------------------------
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

`define MSC_OFS_SRAM_WAIT 8'h00
`define MSC_OFS_FLASH_CFG 8'h04
`define MSC_OFS_STATUS 8'h08

`define MSC_SRAM_WAIT_RST 32'h0000_0009
`define MSC_SRAM_WAIT_MASK 32'h0000_003f
`define MSC_FLASH_CFG_RST 32'h0000_00f1
`define MSC_FLASH_STORE_MASK 32'h0001_7fff

`define MSC_BANK0_LSB 0
`define MSC_BANK1_LSB 3
`define MSC_REMAP_LSB 0
`define MSC_RANGE0_LSB 5
`define MSC_RANGE1_LSB 9
`define MSC_DPD0_BIT 13
`define MSC_DPD1_BIT 14
`define MSC_PERSIST_BIT 15
`define MSC_SENSE_BIT 16

`define MSC_WAIT_ZERO_CYCLES 4'h8
`define MSC_REMAP_MIN 5'h0d
`define MSC_REMAP_MAX 5'h12
`define MSC_RANGE_MIN 4'h2
`define MSC_SAFE_PAGE_WAIT 5'h10
`define MSC_SAFE_PROG_WAIT 3'h7

`endif

// [msc_pkg.sv]
// Types shared by the memory subsystem configuration registers
`default_nettype none

package msc_pkg;

  typedef enum logic {MSC_RD_IDLE, MSC_RD_COUNT} msc_rd_state_t;

  typedef struct packed
  {
    logic [4:0] pageWait;
    logic [2:0] progWait;
    logic unsupported;
  } msc_flash_wait_t;

  typedef struct packed
  {
    logic senseOn;
    logic [1:0] deepPowerdown;
    logic resetLow;
    logic persist;
  } msc_flash_ctl_t;

  typedef struct packed
  {
    logic valid;
    logic [4:0] log2Bytes;
  } msc_remap_t;

endpackage

`default_nettype wire

// [msc_regs.sv]
// Memory subsystem configuration registers with SRAM wait limiters and flash read timers
`timescale 1ns/10ps
`default_nettype none
`include "msc_cfg.svh"

module msc_regs
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic power_on_reset_low,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] fixedReq,
  input wire logic [1:0] wrrBusy,
  output logic [1:0] bankPreempt,
  output logic [1:0][3:0] bankMaxWait,
  input wire logic [1:0] flashRdReq,
  input wire logic [1:0] flashRdProgram,
  output logic [1:0] flashBusy,
  output logic [1:0] flashCapture,
  output msc_pkg::msc_flash_wait_t [1:0] flashWait,
  output msc_pkg::msc_flash_ctl_t flashCtl,
  output msc_pkg::msc_remap_t flashRemap
);

  //--------------------------------------------------------------------
  // Decode helpers
  //--------------------------------------------------------------------

  // Zero stands for the longest wait so the reset code 1 is the shortest
  function automatic logic [3:0] waitDecode(input logic [2:0] code);
    logic [3:0] cycles;
    cycles = {1'b0, code};
    if (code == 3'h0)
      cycles = `MSC_WAIT_ZERO_CYCLES;
    return cycles;
  endfunction

  // Unsupported codes fall back to the slowest timing rather than a guess
  function automatic msc_pkg::msc_flash_wait_t rangeDecode(input logic [3:0] code);
    msc_pkg::msc_flash_wait_t w;
    w.pageWait = {1'b0, code} + 5'h1;
    w.unsupported = 1'b0;
    case (code)
      4'h2, 4'h3, 4'h4: w.progWait = 3'h2;
      4'h5, 4'h6: w.progWait = 3'h3;
      4'h7, 4'h8, 4'h9: w.progWait = 3'h4;
      4'ha, 4'hb: w.progWait = 3'h5;
      4'hc, 4'hd, 4'he: w.progWait = 3'h6;
      4'hf: w.progWait = 3'h7;
      default: w.progWait = `MSC_SAFE_PROG_WAIT;
    endcase
    if (code < `MSC_RANGE_MIN)
    begin
      w.pageWait = `MSC_SAFE_PAGE_WAIT;
      w.unsupported = 1'b1;
    end
    return w;
  endfunction

  // Byte-lane merge; the mask keeps reserved bits at zero
  function automatic logic [31:0] laneMerge(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] sel,
    input logic [31:0] mask
  );
    logic [31:0] result;
    result = oldVal;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        result[8*b +: 8] = newVal[8*b +: 8];
    end
    return result & mask;
  endfunction

  //--------------------------------------------------------------------
  // Power-on reset synchroniser
  //--------------------------------------------------------------------

  logic porMeta_reg;
  logic porSync_reg;

  // The pin is asynchronous to clk_sys; no reset so system reset cannot fake it
  always_ff @(posedge clk_sys)
  begin
    if (ce)
    begin
      porMeta_reg <= power_on_reset_low;
      porSync_reg <= porMeta_reg;
    end
  end

  //--------------------------------------------------------------------
  // Wishbone slave
  //--------------------------------------------------------------------

  logic ackReg;
  logic busNew;
  logic wrCommit;
  logic [5:0] sramWait_reg;
  logic [16:0] flashCfg_reg;
  logic persist_reg;
  logic [31:0] flashCfgRead;
  logic [31:0] statusRead;
  logic [31:0] readMux;
  logic [31:0] flashMerged;
  logic [31:0] sramMerged;
  logic [1:0] preempt;
  logic [1:0] busy;

  assign busNew = wb_cyc_i & wb_stb_i & ~ackReg;
  // Writes land on the edge where the master sees ack, as classic cycles expect
  assign wrCommit = wb_cyc_i & wb_stb_i & wb_we_i & ackReg;

  // Persist lives outside the main store because it must survive system reset
  assign flashCfgRead = {15'h0, flashCfg_reg} | ({31'h0, persist_reg} << `MSC_PERSIST_BIT);
  assign statusRead = {25'h0, flashRemap.valid, flashWait[1].unsupported,
                       flashWait[0].unsupported, preempt, busy};
  assign sramMerged = laneMerge({26'h0, sramWait_reg}, wb_dat_i, wb_sel_i,
                                `MSC_SRAM_WAIT_MASK);
  assign flashMerged = laneMerge(flashCfgRead, wb_dat_i, wb_sel_i,
                                 `MSC_FLASH_STORE_MASK);

  // Unmapped and misaligned addresses read as zero
  always_comb
  begin
    case (wb_adr_i)
      `MSC_OFS_SRAM_WAIT: readMux = {26'h0, sramWait_reg};
      `MSC_OFS_FLASH_CFG: readMux = flashCfgRead;
      `MSC_OFS_STATUS: readMux = statusRead;
      default: readMux = 32'h0;
    endcase
  end

  // One wait state: ack and read data appear one edge after the request
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ackReg <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else if (ce)
    begin
      ackReg <= busNew;
      wb_dat_o <= (busNew & ~wb_we_i) ? readMux : 32'h0;
    end
  end

  assign wb_ack_o = ackReg;

  //--------------------------------------------------------------------
  // Configuration storage
  //--------------------------------------------------------------------

  // SRAM wait limits
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      sramWait_reg <= 6'(`MSC_SRAM_WAIT_RST);
    else if (ce && wrCommit && wb_adr_i == `MSC_OFS_SRAM_WAIT)
      sramWait_reg <= sramMerged[5:0];
  end

  // Flash controls other than persist follow system reset
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      flashCfg_reg <= 17'(`MSC_FLASH_CFG_RST);
    else if (ce && wrCommit && wb_adr_i == `MSC_OFS_FLASH_CFG)
      flashCfg_reg <= flashMerged[16:0];
  end

  // Persist is cleared only by power-on reset, else it could not hold its choice
  always_ff @(posedge clk_sys)
  begin
    if (!porSync_reg)
      persist_reg <= 1'b0;
    else if (ce && rstn && wrCommit && wb_sel_i[1] && wb_adr_i == `MSC_OFS_FLASH_CFG)
      persist_reg <= wb_dat_i[`MSC_PERSIST_BIT];
  end

  //--------------------------------------------------------------------
  // Decoded outputs
  //--------------------------------------------------------------------

  logic [4:0] remapCode;
  logic [3:0] range0;
  logic [3:0] range1;

  assign remapCode = flashCfg_reg[`MSC_REMAP_LSB +: 5];
  assign range0 = flashCfg_reg[`MSC_RANGE0_LSB +: 4];
  assign range1 = flashCfg_reg[`MSC_RANGE1_LSB +: 4];

  // Registered decode; outputs trail the stored fields by one edge
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      bankMaxWait <= '0;
      flashWait <= '0;
      flashRemap <= '0;
    end
    else if (ce)
    begin
      bankMaxWait[0] <= waitDecode(sramWait_reg[`MSC_BANK0_LSB +: 3]);
      bankMaxWait[1] <= waitDecode(sramWait_reg[`MSC_BANK1_LSB +: 3]);
      flashWait[0] <= rangeDecode(range0);
      flashWait[1] <= rangeDecode(range1);
      // Segment size is two to the power of code plus one; reserved codes decode to zero
      if (remapCode >= `MSC_REMAP_MIN && remapCode <= `MSC_REMAP_MAX)
        flashRemap <= {1'b1, remapCode + 5'h1};
      else
        flashRemap <= '0;
    end
  end

  //--------------------------------------------------------------------
  // Flash array reset
  //--------------------------------------------------------------------

  // One process owns the whole control word; during system reset the persist bit decides
  always_ff @(posedge clk_sys)
  begin
    if (!porSync_reg)
      flashCtl <= '0;
    else
    begin
      flashCtl.persist <= persist_reg;
      if (!rstn)
      begin
        flashCtl.senseOn <= 1'b0;
        flashCtl.deepPowerdown <= 2'h0;
        flashCtl.resetLow <= persist_reg;
      end
      else
      begin
        flashCtl.resetLow <= 1'b1;
        if (ce)
          flashCtl.senseOn <= flashCfg_reg[`MSC_SENSE_BIT];
        if (ce)
          flashCtl.deepPowerdown <= flashCfg_reg[`MSC_DPD0_BIT +: 2];
      end
    end
  end

  //--------------------------------------------------------------------
  // SRAM bank wait limiters
  //--------------------------------------------------------------------

  for (genvar g = 0; g < 2; g++)
  begin : gBank
    logic [3:0] waitCount_reg;
    logic preempt_reg;
    logic contended;

    assign contended = fixedReq[g] & wrrBusy[g];

    // Counts the cycles the fixed master has waited; grants it at the limit
    always_ff @(posedge clk_sys)
    begin
      if (!rstn)
      begin
        waitCount_reg <= 4'h0;
        preempt_reg <= 1'b0;
      end
      else if (ce)
      begin
        if (!contended)
        begin
          waitCount_reg <= 4'h0;
          preempt_reg <= 1'b0;
        end
        else if (waitCount_reg + 4'h1 >= bankMaxWait[g])
          preempt_reg <= 1'b1;
        else
          waitCount_reg <= waitCount_reg + 4'h1;
      end
    end

    assign preempt[g] = preempt_reg;
  end

  assign bankPreempt = preempt;

  //--------------------------------------------------------------------
  // Flash read wait-state timers
  //--------------------------------------------------------------------

  for (genvar g = 0; g < 2; g++)
  begin : gFlash
    msc_pkg::msc_rd_state_t state_reg;
    logic [4:0] count_reg;
    logic busy_reg;
    logic capture_reg;
    logic usable;

    // A powered-down array or one with its sense amps off ignores requests
    assign usable = flashCtl.senseOn & ~flashCtl.deepPowerdown[g];

    // Busy for the programmed wait states, then a one-cycle capture strobe
    always_ff @(posedge clk_sys)
    begin
      if (!rstn)
      begin
        state_reg <= msc_pkg::MSC_RD_IDLE;
        count_reg <= 5'h0;
        busy_reg <= 1'b0;
        capture_reg <= 1'b0;
      end
      else if (ce)
      begin
        capture_reg <= 1'b0;
        case (state_reg)
          msc_pkg::MSC_RD_IDLE:
          begin
            if (flashRdReq[g] & usable)
            begin
              if (flashRdProgram[g])
                count_reg <= {2'h0, flashWait[g].progWait};
              else
                count_reg <= flashWait[g].pageWait;
              busy_reg <= 1'b1;
              state_reg <= msc_pkg::MSC_RD_COUNT;
            end
          end
          msc_pkg::MSC_RD_COUNT:
          begin
            if (count_reg <= 5'h1)
            begin
              busy_reg <= 1'b0;
              capture_reg <= 1'b1;
              state_reg <= msc_pkg::MSC_RD_IDLE;
            end
            else
              count_reg <= count_reg - 5'h1;
          end
          default:
          begin
            busy_reg <= 1'b0;
            state_reg <= msc_pkg::MSC_RD_IDLE;
          end
        endcase
      end
    end

    assign busy[g] = busy_reg;
    assign flashCapture[g] = capture_reg;
  end

  assign flashBusy = busy;

endmodule

`default_nettype wire

// [msc_regs_properties.sv]
// Checker for the memory config register bank ports
`timescale 1ns/10ps
`default_nettype none
module msc_regs_properties
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] fixedReq,
  input wire logic [1:0] wrrBusy,
  input wire logic [1:0] bankPreempt,
  input wire logic [1:0][3:0] bankMaxWait,
  input wire logic [1:0] flashRdReq,
  input wire logic [1:0] flashRdProgram,
  input wire logic [1:0] flashBusy,
  input wire logic [1:0] flashCapture,
  input wire msc_pkg::msc_flash_wait_t [1:0] flashWait,
  input wire msc_pkg::msc_flash_ctl_t flashCtl
);
  logic [1:0][4:0] contCnt;
  logic [4:0] busyLen;
  logic [4:0] expWait;
  logic progMode;
  // ------
  // Helpers
  // ------
  // Contention run per bank; saturates so long stalls cannot wrap
  always_ff @(posedge clk_sys)
  begin
    for (int g = 0; g < 2; g++)
    begin
      if (!rstn || !(fixedReq[g] && wrrBusy[g]))
        contCnt[g] <= 5'h00;
      else if (contCnt[g] != 5'h1f)
        contCnt[g] <= contCnt[g] + 5'h01;
    end
  end
  // Busy length of array zero
  always_ff @(posedge clk_sys)
  begin
    busyLen <= (rstn && flashBusy[0]) ? busyLen + 5'h01 : 5'h00;
  end
  // Refused requests also latch the mode; harmless, no busy follows
  always_ff @(posedge clk_sys)
  begin
    if (flashRdReq[0] && !flashBusy[0])
      progMode <= flashRdProgram[0];
  end
  // Unsupported codes fall back to the slowest timing
  assign expWait = flashWait[0].unsupported ? (progMode ? 5'h07 : 5'h10) :
    (progMode ? {2'h0, flashWait[0].progWait} : flashWait[0].pageWait);
  // ------
  // Assertions
  // ------
  ack_latency_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_pulse_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  idle_data_zero_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  bank0_preempt_a:
    assert property (@(posedge clk_sys) disable iff (!rstn) bankMaxWait[0] != 4'h0
      |-> bankPreempt[0] == (contCnt[0] >= {1'b0, bankMaxWait[0]})) else $error("bank0 wait");
  bank1_preempt_a:
    assert property (@(posedge clk_sys) disable iff (!rstn) bankMaxWait[1] != 4'h0
      |-> bankPreempt[1] == (contCnt[1] >= {1'b0, bankMaxWait[1]})) else $error("bank1 wait");
  busy_length_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(flashBusy[0]) |-> busyLen == expWait) else $error("busy length");
  capture_follows_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(flashBusy[0]) |-> flashCapture[0] ##1 !flashCapture[0]) else $error("capture");
  read_refused_a:
    assert property (@(posedge clk_sys) disable iff (!rstn) flashRdReq[0] && !flashBusy[0]
      && (!flashCtl.senseOn || flashCtl.deepPowerdown[0]) |=> !flashBusy[0])
      else $error("read not refused");
endmodule
bind msc_regs msc_regs_properties msc_regs_properties_i
(
  .clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .fixedReq,
  .wrrBusy, .bankPreempt, .bankMaxWait, .flashRdReq, .flashRdProgram,
  .flashBusy, .flashCapture, .flashWait, .flashCtl
);
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the memory config register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic porLow = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [1:0] fixedReq = 2'h0;
  logic [1:0] wrrBusy = 2'h0;
  logic [1:0] flashRdReq = 2'h0;
  logic [1:0] flashRdProgram = 2'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o;
  logic [1:0] bankPreempt;
  logic [1:0] flashBusy;
  logic [1:0] flashCapture;
  logic [1:0][3:0] bankMaxWait;
  msc_pkg::msc_flash_wait_t [1:0] flashWait;
  msc_pkg::msc_flash_ctl_t flashCtl;
  msc_pkg::msc_remap_t flashRemap;
  int fails = 0;
  int checksDone = 0;
  // ------
  // Clock and design
  // ------
  always #20 clk_sys = ~clk_sys;
  msc_regs msc_regs_i
  (
    .clk_sys, .rstn, .ce(1'b1), .power_on_reset_low(porLow), .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .fixedReq,
    .wrrBusy, .bankPreempt, .bankMaxWait, .flashRdReq, .flashRdProgram, .flashBusy,
    .flashCapture, .flashWait, .flashCtl, .flashRemap
  );
  // ------
  // Helpers
  // ------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [3:0] dec(input logic [2:0] c);
    return (c == 3'h0) ? 4'h8 : {1'b0, c};
  endfunction
  function automatic logic [4:0] prog(input int c);
    return (c < 5) ? 5'h02 : (c < 7) ? 5'h03 : (c < 10) ? 5'h04 :
      (c < 12) ? 5'h05 : (c < 15) ? 5'h06 : 5'h07;
  endfunction
  // Classic cycle held until ack; waits are bounded so a dead slave cannot hang us
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    chk("ack", 32'h1, wb_ack_o);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  // One read start; counts busy cycles, then expects the capture pulse only when busy cycles are expected
  task automatic rdx(input int g, input logic p, input logic [4:0] w);
    int n;
    n = 0;
    @(posedge clk_sys);
    flashRdReq[g] <= 1'b1;
    flashRdProgram[g] <= p;
    @(posedge clk_sys);
    flashRdReq[g] <= 1'b0;
    #1;
    while (flashBusy[g] === 1'b1 && n < 40)
    begin
      n++;
      @(posedge clk_sys);
      #1;
    end
    chk("busy cycles", w, n);
    chk("capture", w != 5'h00, flashCapture[g]);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    wb(1'b0, 8'h00, 32'h0);
    chk("sram word", 32'h0000_0009, rd);
    wb(1'b0, 8'h04, 32'h0);
    chk("flash word", 32'h0000_00f1, rd);
    chk("max wait", 32'h11, bankMaxWait);
    chk("wait0", {5'h08, 3'h4}, {flashWait[0].pageWait, flashWait[0].progWait});
    chk("remap", 32'h32, flashRemap);
    $display("test reset done");
  endtask
  task automatic t_wait;
    for (int v = 0; v < 8; v++)
    begin
      wb(1'b1, 8'h00, {26'h3ffffff, 3'(7 - v), 3'(v)});
      chk("max wait", {dec(3'(7 - v)), dec(3'(v))}, bankMaxWait);
      wb(1'b0, 8'h00, 32'h0);
      chk("sram word", {26'h0, 3'(7 - v), 3'(v)}, rd);
    end
    $display("test wait decode done");
  endtask
  task automatic t_preempt(input int g, input logic [2:0] code);
    int n;
    n = 0;
    wb(1'b1, 8'h00, {26'h0, code, code});
    @(posedge clk_sys);
    fixedReq[g] <= 1'b1;
    wrrBusy[g] <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (bankPreempt[g] !== 1'b1 && n < 20);
    chk("preempt wait", dec(code), n);
    @(posedge clk_sys);
    wrrBusy[g] <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("preempt end", 32'h0, bankPreempt[g]);
    $display("test preempt done");
  endtask
  // Array zero in both timing modes, array one in page mode, every supported range code
  task automatic t_flash;
    for (int c = 2; c < 16; c++)
    begin
      wb(1'b1, 8'h04, {15'h0, 1'b1, 3'h0, 4'(17 - c), 4'(c), 5'h11});
      rdx(0, 1'b0, 5'(c + 1));
      rdx(0, 1'b1, prog(c));
      rdx(1, 1'b0, 5'(18 - c));
    end
    wb(1'b1, 8'h04, 32'h0000_00f1);
    rdx(0, 1'b0, 5'h00);
    wb(1'b1, 8'h04, 32'h0001_20f1);
    rdx(0, 1'b0, 5'h00);
    rdx(1, 1'b0, 5'h10);
    wb(1'b0, 8'h08, 32'h0);
    chk("status", 32'h0000_0060, rd);
    wb(1'b1, 8'h04, 32'h0001_40f1);
    chk("flash control", 32'h1a, flashCtl);
    rdx(1, 1'b0, 5'h00);
    rdx(0, 1'b0, 5'h08);
    $display("test flash timing done");
  endtask
  task automatic t_remap;
    for (int c = 12; c < 19; c++)
    begin
      wb(1'b1, 8'h04, 32'hfffe_0000 | c);
      chk("remap", (c > 12) ? 32'h21 + c : 32'h0, flashRemap);
      wb(1'b0, 8'h04, 32'h0);
      chk("flash word", c, rd);
    end
    wb(1'b1, 8'h0c, 32'hffff_ffff);
    wb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test remap done");
  endtask
  // Persist must survive a system reset but not a power-on reset
  task automatic t_persist;
    wb(1'b1, 8'h04, 32'h0000_80f1);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("reset source", 32'h1, flashCtl.resetLow);
    @(posedge clk_sys);
    rstn <= 1'b1;
    wb(1'b0, 8'h04, 32'h0);
    chk("flash word", 32'h0000_80f1, rd);
    @(posedge clk_sys);
    porLow <= 1'b0;
    repeat (5) @(posedge clk_sys);
    porLow <= 1'b1;
    #1;
    chk("power-on source", 32'h0, flashCtl.resetLow);
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("reset source", 32'h0, flashCtl.resetLow);
    @(posedge clk_sys);
    rstn <= 1'b1;
    wb(1'b0, 8'h04, 32'h0);
    chk("flash word", 32'h0000_00f1, rd);
    $display("test persist done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------
  // Main sequence and watchdog
  // ------
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    porLow <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Once-only power-up fields live in other blocks and are never written here
    t_reset;
    t_wait;
    t_preempt(0, 3'h0);
    t_preempt(1, 3'h5);
    t_flash;
    t_remap;
    t_persist;
    end_of_test;
  end
  // Run needs under a thousand cycles; this only cuts a hang short
  initial
  begin
    #800000;
    fails++;
    end_of_test;
  end
endmodule
`default_nettype wire
